// [rtl/tx_char_encoder_defines.vh]
// Constants for the dual-channel transmit character encoder.
// Assumes three-level pins arrive already resolved to two-bit codes.
`ifndef TX_CHAR_ENCODER_DEFINES_VH
`define TX_CHAR_ENCODER_DEFINES_VH

// Three-level pin codes
`define TL_LOW      2'h0
`define TL_MID      2'h1
`define TL_HIGH     2'h2

// Character kinds from the control decode
`define KD_DATA     2'h0
`define KD_FILL     2'h1
`define KD_SPEC     2'h2
`define KD_SYNC     2'h3

// Code points
`define K28_5_BYTE  8'hBC
`define K28_X       5'h1C
`define K28_6B      6'h0F
`define D7_X        5'h07
`define ALT7_4B     4'h7
`define Y3          3'h3
`define Y7          3'h7
`define BAL6        4'h3
`define BAL4        4'h2
`define VIOL_POS    10'h079
`define CTL_NONE    2'h0

// Word sync sequence positions
`define WS_FIRST    4'h0
`define WS_REV_A    4'h1
`define WS_REV_B    4'h2
`define WS_LAST     4'hF
`define WS_STEP     4'h1

// Self-test generator
`define BIST_SEED   9'h1FF

`endif

// [rtl/tx_char_encoder.v]
// Dual-channel transmit character encoder with output skid buffers.
// Assumes all inputs synchronous to CLK_SYS; the shifter drains SYM_*.
`include "tx_char_encoder_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module tx_char_encoder #(
    parameter DEPTH = 2  // Output buffer entries, power of two
) (
    input  wire        CLK_SYS,          // System clock, 25 MHz
    input  wire        SRST,             // Synchronous reset, high
    input  wire [3:0]  TX_MODE_SEL,      // [3:2] mode bit 1, [1:0] bit 0
    input  wire [1:0]  TX_CLOCK_SEL,     // Three-level clock select
    input  wire [1:0]  PARITY_CHECK_CTL, // Three-level parity control
    input  wire        SPECIAL_CODE_SEL, // Special code select
    input  wire        BIST_ENABLE,      // Send self-test sequence
    input  wire [1:0]  CHAR_VALID,       // Character offered, per chan
    output wire [1:0]  CHAR_READY,       // Character taken, per chan
    input  wire [15:0] CHAR_DATA,        // Data bits, A in [7:0]
    input  wire [3:0]  CHAR_CONTROL,     // Control bits, A in [1:0]
    input  wire [1:0]  ODD_PARITY,       // Odd parity bits
    input  wire [1:0]  PAB_ERROR,        // Phase-align buffer error
    output wire [1:0]  TX_ERROR_FLAG,    // Transmit error, per chan
    output wire [1:0]  SYM_VALID,        // Symbol available
    input  wire [1:0]  SYM_READY,        // Shifter takes symbol
    output wire [19:0] SYM_DATA          // Symbols, bit 0 sent first
);

    localparam PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    wire [1:0] mode_hi   = TX_MODE_SEL[3:2];
    wire [1:0] mode_lo   = TX_MODE_SEL[1:0];
    wire       encoded   = (mode_hi != `TL_LOW);
    wire       atomic    = (mode_hi == `TL_MID);
    wire       interrupt = (mode_hi == `TL_HIGH);
    wire       par_on    = (PARITY_CHECK_CTL != `TL_LOW);
    wire       par_ctl   = (PARITY_CHECK_CTL == `TL_HIGH) | ~encoded;
    wire [1:0] accept    = CHAR_VALID & CHAR_READY;
    reg        sc_hold;

    // With TX_CLOCK_SEL mid, channel B sees the level captured with A's latest character
    wire sc_b = (TX_CLOCK_SEL == `TL_MID) ?
                (accept[0] ? SPECIAL_CODE_SEL : sc_hold) :
                SPECIAL_CODE_SEL;

    always @(posedge CLK_SYS) begin
        if (SRST)
            sc_hold <= 1'b0;
        else if (accept[0])
            sc_hold <= SPECIAL_CODE_SEL;
    end

    function [3:0] ones;
        input [9:0] v;
        integer i;
        begin
            ones = 4'h0;
            for (i = 0; i < 10; i = i + 1)
                ones = ones + {3'h0, v[i]};
        end
    endfunction

    function [5:0] tab6;
        input [4:0] x;
        begin
            case (x)
                5'h00: tab6 = 6'h27;
                5'h01: tab6 = 6'h1D;
                5'h02: tab6 = 6'h2D;
                5'h03: tab6 = 6'h31;
                5'h04: tab6 = 6'h35;
                5'h05: tab6 = 6'h29;
                5'h06: tab6 = 6'h19;
                5'h07: tab6 = 6'h38;
                5'h08: tab6 = 6'h39;
                5'h09: tab6 = 6'h25;
                5'h0A: tab6 = 6'h15;
                5'h0B: tab6 = 6'h34;
                5'h0C: tab6 = 6'h0D;
                5'h0D: tab6 = 6'h2C;
                5'h0E: tab6 = 6'h1C;
                5'h0F: tab6 = 6'h17;
                5'h10: tab6 = 6'h1B;
                5'h11: tab6 = 6'h23;
                5'h12: tab6 = 6'h13;
                5'h13: tab6 = 6'h32;
                5'h14: tab6 = 6'h0B;
                5'h15: tab6 = 6'h2A;
                5'h16: tab6 = 6'h1A;
                5'h17: tab6 = 6'h3A;
                5'h18: tab6 = 6'h33;
                5'h19: tab6 = 6'h26;
                5'h1A: tab6 = 6'h16;
                5'h1B: tab6 = 6'h36;
                5'h1C: tab6 = 6'h0E;
                5'h1D: tab6 = 6'h2E;
                5'h1E: tab6 = 6'h1E;
                default: tab6 = 6'h2B;
            endcase
        end
    endfunction

    function [3:0] tab4;
        input [2:0] y;
        begin
            case (y)
                3'h0: tab4 = 4'hB;
                3'h1: tab4 = 4'h9;
                3'h2: tab4 = 4'h5;
                3'h3: tab4 = 4'hC;
                3'h4: tab4 = 4'hD;
                3'h5: tab4 = 4'hA;
                3'h6: tab4 = 4'h6;
                default: tab4 = 4'hE;
            endcase
        end
    endfunction

    // Returns {new running disparity, symbol}; rd high means positive
    function [10:0] enc;
        input [7:0] d;
        input       k;
        input       rd;
        reg [5:0] s6;
        reg [3:0] s4;
        reg       rd6;
        reg       alt;
        reg [9:0] c;
        integer   i;
        begin
            s6 = (k && d[4:0] == `K28_X) ? `K28_6B : tab6(d[4:0]);
            rd6 = (ones({4'h0, s6}) != `BAL6) ? ~rd : rd;
            if (rd && ((ones({4'h0, s6}) != `BAL6) || d[4:0] == `D7_X))
                s6 = ~s6;
            alt = (d[7:5] == `Y7) && (k ||
                  (~rd6 && s6[1] && s6[0]) || (rd6 && ~s6[1] && ~s6[0]));
            s4 = alt ? `ALT7_4B : tab4(d[7:5]);
            if ((ones({6'h00, s4}) != `BAL4) || d[7:5] == `Y3
                || d[7:5] == `Y7) begin
                if (rd6)
                    s4 = ~s4;
            end else if (k && ~rd6) begin
                s4 = ~s4;
            end
            for (i = 0; i < 6; i = i + 1)
                c[i] = s6[5 - i];
            for (i = 0; i < 4; i = i + 1)
                c[6 + i] = s4[3 - i];
            enc = {(ones({6'h00, s4}) != `BAL4) ? ~rd6 : rd6, c};
        end
    endfunction

    // Violation symbol of proper disparity; it is balanced
    function [10:0] viol;
        input rd;
        begin
            viol = {rd, rd ? ~`VIOL_POS : `VIOL_POS};
        end
    endfunction

    // Table A: low nibble picks K28.0-7, K23/27/29/30.7; table B: K28.y
    function [10:0] spec;
        input [7:0] d;
        input       rd;
        begin
            if (d[7])
                spec = enc({d[2:0], `K28_X}, 1'b1, rd);
            else begin
                case (d[3:0])
                    4'h8: spec = enc(8'hF7, 1'b1, rd);
                    4'h9: spec = enc(8'hFB, 1'b1, rd);
                    4'hA: spec = enc(8'hFD, 1'b1, rd);
                    4'hB: spec = enc(8'hFE, 1'b1, rd);
                    default: begin
                        if (d[3])
                            spec = viol(rd);
                        else
                            spec = enc({d[2:0], `K28_X}, 1'b1, rd);
                    end
                endcase
            end
        end
    endfunction

    function [1:0] kind;
        input [1:0] tbl;
        input       sc;
        input [1:0] ctl;
        begin
            case (tbl)
                `TL_LOW:
                    kind = ~ctl[0] ? `KD_DATA : ctl[1] ? `KD_SYNC :
                           sc ? `KD_SPEC : `KD_FILL;
                `TL_MID:
                    kind = ~ctl[0] ? `KD_DATA : sc ? `KD_SYNC :
                           ctl[1] ? `KD_SPEC : `KD_FILL;
                default:
                    kind = ctl;
            endcase
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : chan
            wire [7:0] d   = CHAR_DATA[8*g +: 8];
            wire [1:0] ctl = CHAR_CONTROL[2*g +: 2];
            wire       sc  = (g == 0) ? SPECIAL_CODE_SEL : sc_b;
            wire par_ok = ^{d, par_ctl ? ctl : `CTL_NONE, ODD_PARITY[g]};
            wire par_bad = par_on & accept[g] & ~par_ok;

            reg [9:0]  mem [0:DEPTH-1];
            reg [PW-1:0] wr_ptr;
            reg [PW-1:0] rd_ptr;
            reg [PW:0] count;
            reg        rd;
            reg        ws_active;
            reg [3:0]  ws_count;
            reg [8:0]  lfsr;
            reg        err_flag;

            reg        gen;
            reg [10:0] res;
            reg        next_rd;
            reg        next_ws_active;
            reg [3:0]  next_ws_count;
            reg [1:0]  k;

            wire space = (count != DEPTH);
            wire pop   = SYM_VALID[g] & SYM_READY[g];

            // Takes chars whenever there is room; stalls back-pressure host
            assign CHAR_READY[g]        = space;
            assign SYM_VALID[g]         = (count != 0);
            assign SYM_DATA[10*g +: 10] = mem[rd_ptr];
            assign TX_ERROR_FLAG[g]     = err_flag;

            always @* begin
                gen            = 1'b0;
                res            = {rd, 10'h000};
                next_ws_active = ws_active;
                next_ws_count  = ws_count;
                k              = kind(mode_lo, sc, ctl);
                if (!encoded) begin
                    // Test modes behave as bypass
                    next_ws_active = 1'b0;
                    gen = accept[g];
                    res = par_bad ? {rd, `VIOL_POS} :
                          {rd, ctl, d};
                end else if (BIST_ENABLE) begin
                    gen = space;
                    res = enc(lfsr[7:0], 1'b0, rd);
                end else if (PAB_ERROR[g]) begin
                    gen = space;
                    res = viol(rd);
                end else if (ws_active && (atomic ||
                             (accept[g] && ctl == `CTL_NONE && ~par_bad)))
                begin
                    // Atomic sequence ignores inputs
                    gen = space;
                    next_ws_count  = ws_count + `WS_STEP;
                    next_ws_active = (ws_count != `WS_LAST);
                    // Second and third sync chars reverse disparity
                    if (ws_count == `WS_REV_A || ws_count == `WS_REV_B) begin
                        res     = enc(`K28_5_BYTE, 1'b1, ~rd);
                        res[10] = rd;
                    end else begin
                        res = enc(`K28_5_BYTE, 1'b1, rd);
                    end
                end else if (accept[g]) begin
                    gen = 1'b1;
                    next_ws_active = 1'b0;
                    if (par_bad)
                        res = viol(rd);
                    else if (k == `KD_DATA)
                        res = enc(d, 1'b0, rd);
                    else if (k == `KD_FILL)
                        res = enc(`K28_5_BYTE, 1'b1, rd);
                    else if (k == `KD_SPEC)
                        res = spec(d, rd);
                    else begin
                        // First sync char follows normal coding
                        next_ws_active = 1'b1;
                        next_ws_count  = `WS_FIRST + `WS_STEP;
                        res = enc(`K28_5_BYTE, 1'b1, rd);
                    end
                end
                next_rd = res[10];
            end

            always @(posedge CLK_SYS) begin
                if (SRST) begin
                    wr_ptr    <= {PW{1'b0}};
                    rd_ptr    <= {PW{1'b0}};
                    count     <= {(PW+1){1'b0}};
                    rd        <= 1'b0;
                    ws_active <= 1'b0;
                    ws_count  <= `WS_FIRST;
                    lfsr      <= `BIST_SEED;
                    err_flag  <= 1'b0;
                end else begin
                    if (gen) begin
                        mem[wr_ptr] <= res[9:0];
                        wr_ptr      <= wr_ptr + 1'b1;
                        rd          <= next_rd;
                        ws_active   <= next_ws_active;
                        ws_count    <= next_ws_count;
                    end
                    if (pop)
                        rd_ptr <= rd_ptr + 1'b1;
                    if (gen && !pop)
                        count <= count + 1'b1;
                    else if (!gen && pop)
                        count <= count - 1'b1;
                    // Period 511 from taps 9 and 5
                    if (!BIST_ENABLE)
                        lfsr <= `BIST_SEED;
                    else if (gen)
                        lfsr <= {lfsr[7:0], lfsr[8] ^ lfsr[4]};
                    err_flag <= PAB_ERROR[g] | par_bad;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// [verif/tx_char_encoder_chk.sv]
// Port assertions for the transmit character encoder.
// Assumes one clock domain, CLK_SYS, with SRST as its reset.
`timescale 1ns/1ns
`default_nettype none
module tx_char_encoder_chk (
    input wire        CLK_SYS,          // Clock
    input wire        SRST,             // Reset
    input wire [3:0]  TX_MODE_SEL,      // Mode select
    input wire [1:0]  PARITY_CHECK_CTL, // Parity control
    input wire        BIST_ENABLE,      // Self-test
    input wire [1:0]  CHAR_VALID,       // Char offered
    input wire [1:0]  CHAR_READY,       // Char taken
    input wire [15:0] CHAR_DATA,        // Data bits
    input wire [3:0]  CHAR_CONTROL,     // Control bits
    input wire [1:0]  ODD_PARITY,       // Parity bits
    input wire [1:0]  PAB_ERROR,        // Align error
    input wire [1:0]  TX_ERROR_FLAG,    // Error flags
    input wire [1:0]  SYM_VALID,        // Symbol valid
    input wire [1:0]  SYM_READY,        // Symbol taken
    input wire [19:0] SYM_DATA          // Symbols
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    // Accepted into an empty buffer, so the next cycle shows it
    wire clean0 = CHAR_VALID[0] & CHAR_READY[0] & ~SYM_VALID[0] & ~PAB_ERROR[0];
    wire clean1 = CHAR_VALID[1] & CHAR_READY[1] & ~SYM_VALID[1] & ~PAB_ERROR[1];
    wire par0   = ^{CHAR_CONTROL[1:0], CHAR_DATA[7:0], ODD_PARITY[0]};
    wire byp    = TX_MODE_SEL[3:2] == 2'h0;

    sym_hold_a: assert property (SYM_VALID[0] && !SYM_READY[0] |=>
        SYM_VALID[0] && $stable(SYM_DATA[9:0])) else $error("symbol A lost");
    symb_hold_a: assert property (SYM_VALID[1] && !SYM_READY[1] |=>
        SYM_VALID[1] && $stable(SYM_DATA[19:10])) else $error("symbol B lost");
    full_nonempty_a: assert property (!CHAR_READY[0] |-> SYM_VALID[0])
        else $error("refusing while empty");
    bypass_map_a: assert property (clean0 && byp && PARITY_CHECK_CTL == 2'h0
        |=> SYM_VALID[0] && SYM_DATA[9:0] == {$past(CHAR_CONTROL[1:0]),
        $past(CHAR_DATA[7:0])}) else $error("bypass A altered");
    bypassb_map_a: assert property (clean1 && byp && PARITY_CHECK_CTL == 2'h0
        |=> SYM_VALID[1] && SYM_DATA[19:10] == {$past(CHAR_CONTROL[3:2]),
        $past(CHAR_DATA[15:8])}) else $error("bypass B altered");
    bypass_par_a: assert property (clean0 && byp && PARITY_CHECK_CTL == 2'h2
        && !par0 |=> SYM_DATA[9:0] == 10'h079) else $error("no violation");
    par_flag_a: assert property (CHAR_VALID[0] && CHAR_READY[0] && byp &&
        PARITY_CHECK_CTL != 2'h0 && !par0 |=> TX_ERROR_FLAG[0])
        else $error("parity flag missing");
    pab_flag_a: assert property (PAB_ERROR[0] |=> TX_ERROR_FLAG[0])
        else $error("align flag missing");
    pab_viol_a: assert property ((PAB_ERROR[0] && SYM_READY[0] && !byp)[*4]
        |-> !SYM_VALID[0] || SYM_DATA[9:0] inside {10'h079, 10'h386})
        else $error("align error not violation");
    fill_char_a: assert property (clean0 && TX_MODE_SEL == 4'h6 &&
        CHAR_CONTROL[1:0] == 2'h1 && PARITY_CHECK_CTL == 2'h0 && !BIST_ENABLE
        |=> SYM_DATA[9:0] inside {10'h17C, 10'h283}) else $error("fill wrong");
endmodule
bind tx_char_encoder tx_char_encoder_chk u_chk (.CLK_SYS(CLK_SYS),
    .SRST(SRST), .TX_MODE_SEL(TX_MODE_SEL), .BIST_ENABLE(BIST_ENABLE),
    .PARITY_CHECK_CTL(PARITY_CHECK_CTL), .CHAR_VALID(CHAR_VALID),
    .CHAR_READY(CHAR_READY), .CHAR_DATA(CHAR_DATA), .PAB_ERROR(PAB_ERROR),
    .CHAR_CONTROL(CHAR_CONTROL), .ODD_PARITY(ODD_PARITY),
    .TX_ERROR_FLAG(TX_ERROR_FLAG), .SYM_VALID(SYM_VALID),
    .SYM_READY(SYM_READY), .SYM_DATA(SYM_DATA));
`default_nettype wire

// [verif/sym_sink.sv]
// Stand-in for the transmit shifter: queues every symbol it takes.
// Assumes stall is changed by the bench just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module sym_sink (
    input  wire       clk,   // System clock
    input  wire       valid, // Symbol offered
    input  wire [9:0] data,  // Symbol, bit a in bit 0
    input  wire       stall, // Hold off taking
    output logic      ready  // Taking symbols
);
    logic [9:0] q[$];
    initial ready = 1'b0;
    // Registered ready: a slow shifter answers one cycle late
    always @(posedge clk) begin
        if (valid && ready) begin
            q.push_back(data);
        end
        ready <= !stall;
    end
endmodule
`default_nettype wire

// [verif/tb_tx_char_encoder.sv]
// Bench for the transmit character encoder, channel A mostly.
// Assumes sym_sink models the shifter; checker comes in by bind.
`timescale 1ns/1ns
`default_nettype none
module tb_tx_char_encoder;
    logic        CLK_SYS = 1'b0;
    logic        SRST = 1'b1;
    logic [3:0]  TX_MODE_SEL = 4'h0;
    logic [1:0]  PARITY_CHECK_CTL = 2'h0;
    logic        SPECIAL_CODE_SEL = 1'b0;
    logic [1:0]  CHAR_VALID = 2'h0;
    logic [15:0] CHAR_DATA = 16'h0000;
    logic [3:0]  CHAR_CONTROL = 4'h0;
    logic [1:0]  ODD_PARITY = 2'h0;
    logic [1:0]  PAB_ERROR = 2'h0;
    logic [1:0]  stall = 2'h0;
    logic [1:0]  rd = 2'h0;
    wire  [1:0]  CHAR_READY, TX_ERROR_FLAG, SYM_VALID, SYM_READY;
    wire  [19:0] SYM_DATA;
    int          n_errors = 0;
    int          n_checks = 0;

    always #20 CLK_SYS = ~CLK_SYS;

    tx_char_encoder uut (.CLK_SYS(CLK_SYS), .SRST(SRST),
        .TX_MODE_SEL(TX_MODE_SEL), .TX_CLOCK_SEL(2'h0),
        .PARITY_CHECK_CTL(PARITY_CHECK_CTL), .SPECIAL_CODE_SEL(SPECIAL_CODE_SEL),
        .BIST_ENABLE(1'b0), .CHAR_VALID(CHAR_VALID), .CHAR_READY(CHAR_READY),
        .CHAR_DATA(CHAR_DATA), .CHAR_CONTROL(CHAR_CONTROL),
        .ODD_PARITY(ODD_PARITY), .PAB_ERROR(PAB_ERROR),
        .TX_ERROR_FLAG(TX_ERROR_FLAG), .SYM_VALID(SYM_VALID),
        .SYM_READY(SYM_READY), .SYM_DATA(SYM_DATA));
    sym_sink sa (.clk(CLK_SYS), .valid(SYM_VALID[0]), .data(SYM_DATA[9:0]),
        .stall(stall[0]), .ready(SYM_READY[0]));
    sym_sink sb (.clk(CLK_SYS), .valid(SYM_VALID[1]), .data(SYM_DATA[19:10]),
        .stall(stall[1]), .ready(SYM_READY[1]));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp,
                       input string m);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic tmo(input string m);
        n_errors++;
        $display("mismatch at %0t: %s", $time, m);
        end_sim();
    endtask
    // Starts just after an edge, ends at the accepting edge
    task automatic send(input int ch, input logic [1:0] c,
                        input logic [7:0] d, input logic bad);
        int   i;
        logic ok;
        CHAR_VALID[ch] <= 1'b1;
        CHAR_CONTROL[ch*2+:2] <= c;
        CHAR_DATA[ch*8+:8] <= d;
        ODD_PARITY[ch] <= bad ^ ~^((TX_MODE_SEL[3:2] == 2'h0 ||
            PARITY_CHECK_CTL == 2'h2) ? {c, d} : {2'h0, d});
        i = 0;
        do begin
            @(negedge CLK_SYS) ok = CHAR_READY[ch];
            @(posedge CLK_SYS) i++;
        end while (!ok && i < 100);
        if (!ok) tmo("char refused");
    endtask
    task automatic idle();
        CHAR_VALID <= 2'h0;
        @(posedge CLK_SYS);
    endtask
    task automatic exp_sym(input int ch, input logic [9:0] e, input string m);
        int i;
        i = 0;
        while ((ch ? sb.q.size() : sa.q.size()) == 0) begin
            @(posedge CLK_SYS) #1 i++;
            if (i > 100) tmo("no symbol");
        end
        chk(ch ? sb.q.pop_front() : sa.q.pop_front(), e, m);
    endtask
    task automatic k5(input int ch, input logic rev, input string m);
        exp_sym(ch, (rd[ch] ^ rev) ? 10'h283 : 10'h17C, m);
        if (!rev) rd[ch] = !rd[ch];
    endtask
    task automatic sync16();
        for (int p = 1; p <= 16; p++) k5(0, p == 2 || p == 3, "sync");
    endtask
    task automatic setup(input logic [3:0] m, input logic [1:0] p);
        @(posedge CLK_SYS);
        TX_MODE_SEL <= m;
        PARITY_CHECK_CTL <= p;
        @(posedge CLK_SYS);
    endtask

    task automatic t_bypass();
        for (int m = 0; m < 3; m++) begin
            for (int ch = 0; ch < 2; ch++) begin
                setup(4'(m), 2'(2 - m));
                SPECIAL_CODE_SEL <= 1'(ch);
                send(ch, 2'h2, 8'hA5, 1'b0);
                send(ch, 2'h1, 8'h3C, m != 2);
                idle();
                exp_sym(ch, 10'h2A5, "bypass");
                exp_sym(ch, (m != 2) ? 10'h079 : 10'h13C, "bypass par");
            end
        end
        $display("test bypass done");
    endtask
    task automatic t_stall();
        setup(4'h0, 2'h0);
        stall[0] <= 1'b1;
        send(0, 2'h0, 8'h11, 1'b0);
        send(0, 2'h0, 8'h22, 1'b0);
        idle();
        @(negedge CLK_SYS) chk(10'(CHAR_READY[0]), 10'h000, "full");
        @(posedge CLK_SYS) stall[0] <= 1'b0;
        send(0, 2'h0, 8'h33, 1'b0);
        idle();
        exp_sym(0, 10'h011, "order 1");
        exp_sym(0, 10'h022, "order 2");
        exp_sym(0, 10'h033, "order 3");
        $display("test stall done");
    endtask
    task automatic t_mode5();
        setup(4'h6, 2'h0);
        SPECIAL_CODE_SEL <= 1'b1;
        send(0, 2'h0, 8'h00, 1'b0);
        send(0, 2'h1, 8'h80, 1'b0);
        send(0, 2'h2, 8'h80, 1'b0);
        send(0, 2'h2, 8'h00, 1'b0);
        idle();
        exp_sym(0, rd[0] ? 10'h346 : 10'h0B9, "data");
        k5(0, 1'b0, "fill");
        exp_sym(0, rd[0] ? 10'h343 : 10'h0BC, "table one");
        exp_sym(0, rd[0] ? 10'h343 : 10'h0BC, "table two");
        setup(4'h6, 2'h1);
        send(0, 2'h0, 8'h07, 1'b1);
        send(0, 2'h3, 8'hBC, 1'b0);
        idle();
        exp_sym(0, rd[0] ? 10'h386 : 10'h079, "encoded parity");
        sync16();
        $display("test mode5 done");
    endtask
    task automatic t_mode3();
        setup(4'h4, 2'h0);
        SPECIAL_CODE_SEL <= 1'b0;
        send(0, 2'h1, 8'h80, 1'b0);
        SPECIAL_CODE_SEL <= 1'b1;
        send(0, 2'h1, 8'h80, 1'b0);
        send(0, 2'h3, 8'h00, 1'b0);
        send(0, 2'h1, 8'h80, 1'b0);
        idle();
        k5(0, 1'b0, "fill");
        exp_sym(0, rd[0] ? 10'h343 : 10'h0BC, "special");
        sync16();
        repeat (4) @(posedge CLK_SYS);
        chk(10'(sa.q.size()), 10'h000, "atomic drop");
        $display("test mode3 done");
    endtask
    task automatic t_mode6();
        setup(4'h8, 2'h0);
        SPECIAL_CODE_SEL <= 1'b0;
        send(0, 2'h3, 8'h00, 1'b0);
        send(0, 2'h0, 8'h00, 1'b0);
        send(0, 2'h1, 8'h80, 1'b0);
        send(0, 2'h0, 8'h00, 1'b0);
        idle();
        k5(0, 1'b0, "sync first");
        k5(0, 1'b1, "sync second");
        k5(0, 1'b0, "interrupt fill");
        exp_sym(0, rd[0] ? 10'h346 : 10'h0B9, "after stop");
        $display("test mode6 done");
    endtask
    task automatic t_pab();
        setup(4'h6, 2'h0);
        PAB_ERROR[0] <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        @(negedge CLK_SYS) chk(10'(TX_ERROR_FLAG), 10'h001, "align flag");
        @(posedge CLK_SYS) PAB_ERROR[0] <= 1'b0;
        exp_sym(0, rd[0] ? 10'h386 : 10'h079, "align violation");
        repeat (4) @(posedge CLK_SYS);
        sa.q.delete();
        $display("test pab done");
    endtask

    initial begin
        repeat (8) @(posedge CLK_SYS);
        SRST <= 1'b0;
        @(negedge CLK_SYS);
        chk(10'({CHAR_READY, SYM_VALID, TX_ERROR_FLAG}), 10'h030, "reset");
        t_bypass();
        t_stall();
        t_mode5();
        t_mode3();
        t_mode6();
        t_pab();
        end_sim();
    end
endmodule
`default_nettype wire
